// [spmc_defines.vh]
`ifndef SPMC_DEFINES_VH
`define SPMC_DEFINES_VH

// system clock rate in hertz
`define SPMC_CLK_HZ      32'd100000000

// parameter selectors
`define SPMC_IDX_FSTART  8'h00
`define SPMC_IDX_FLIM1   8'h01
`define SPMC_IDX_INC1    8'h02
`define SPMC_IDX_FLIM2   8'h03
`define SPMC_IDX_INC2    8'h04
`define SPMC_IDX_FMAX    8'h05
`define SPMC_IDX_INC3    8'h06
`define SPMC_IDX_FPOS    8'h07
`define SPMC_IDX_FREF    8'h08
`define SPMC_IDX_STEPS   8'h09
`define SPMC_IDX_FMOTOR  8'h0a
`define SPMC_IDX_FSET    8'h0b
`define SPMC_IDX_FTGT    8'h0d
`define SPMC_IDX_STORE   8'h61
`define SPMC_IDX_LOAD    8'h62
`define SPMC_IDX_DEFAULT 8'h63

// storage depth and array slots
`define SPMC_NPARAM      10
`define SPMC_S_FSTART    4'd0
`define SPMC_S_FLIM1     4'd1
`define SPMC_S_INC1      4'd2
`define SPMC_S_FLIM2     4'd3
`define SPMC_S_INC2      4'd4
`define SPMC_S_FMAX      4'd5
`define SPMC_S_INC3      4'd6
`define SPMC_S_FPOS      4'd7
`define SPMC_S_FREF      4'd8
`define SPMC_S_STEPS     4'd9

// factory defaults
`define SPMC_DEF_FSTART  32'd200
`define SPMC_DEF_FLIM1   32'd4000
`define SPMC_DEF_INC1    32'd100
`define SPMC_DEF_FLIM2   32'd10000
`define SPMC_DEF_INC2    32'd60
`define SPMC_DEF_FMAX    32'd15000
`define SPMC_DEF_INC3    32'd40
`define SPMC_DEF_FPOS    32'd15000
`define SPMC_DEF_FREF    32'd1000
`define SPMC_DEF_STEPS   32'd10

// limits
`define SPMC_FSTART_MIN  32'd125
`define SPMC_FMAX_LIMIT  32'd25000
`define SPMC_STEPS_MIN   32'd10

// mode codes
`define SPMC_MODE_IDLE   8'h00
`define SPMC_MODE_REL    8'h01
`define SPMC_MODE_RUN    8'h03
`define SPMC_MODE_PARAM  8'h05
`define SPMC_MODE_ABS    8'h08

`endif

// [spmc_host.sv]
`timescale 1ns/10ps
// host logic model: places the command block on the shared clock
module spmc_host (
    // clock
    input wire logic        clock,
    // command block
    output logic     [31:0] cmd_position,
    output logic     [31:0] cmd_frequency,
    output logic     [7:0]  cmd_mode,
    output logic     [7:0]  cmd_index,
    output logic     [31:0] cmd_value
);
    // idle block at time zero so nothing fires on reset release
    initial begin
        {cmd_position, cmd_frequency, cmd_index, cmd_value} = '0;
        cmd_mode = 8'h00;
    end
    // whole block set beside the mode byte
    // mode held one cycle, then back through idle
    task automatic send(input logic [7:0] m, input logic [31:0] p, input logic [31:0] f,
                        input logic [7:0] i, input logic [31:0] v);
        @(posedge clock);
        cmd_position  <= p;
        cmd_frequency <= f;
        cmd_index     <= i;
        cmd_value     <= v;
        cmd_mode      <= m;
        @(posedge clock);
        cmd_mode      <= 8'h00;
    endtask
endmodule

// [spmc_props.sv]
`timescale 1ns/10ps
// pin-level checker for the pulse-generation control block
module spmc_props (
    // clock and reset
    input wire logic        clock,
    input wire logic        rst_b,
    // command block
    input wire logic [31:0] cmd_position,
    input wire logic [31:0] cmd_frequency,
    input wire logic [7:0]  cmd_mode,
    input wire logic [7:0]  cmd_index,
    input wire logic [31:0] cmd_value,
    // parameter access port
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // limits and drive outputs
    input wire logic        travel_limit_a_b,
    input wire logic        travel_limit_b_b,
    input wire logic        pulse_out,
    input wire logic        dir_out,
    input wire logic        axis_in_motion_output,
    input wire logic        position_reached_output
);
    default clocking dc @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_pulse_in_motion:
        assert property (pulse_out |-> $past(axis_in_motion_output))
        else $error("pulse outside move");
    // 25000 Hz top rate leaves thousands of cycles between pulses
    a_pulse_gap:
        assert property (pulse_out |=> !pulse_out [*8]) else $error("pulses too close");
    a_dir_steady:
        assert property (axis_in_motion_output && $past(axis_in_motion_output) |-> $stable(dir_out))
        else $error("direction changed in motion");
    a_motion_reached:
        assert property (!(axis_in_motion_output && position_reached_output))
        else $error("motion and reached together");
    a_rdata_hold:
        assert property (!$past(reg_rd) |-> $stable(reg_rdata)) else $error("read data moved");
    a_unmapped_zero:
        assert property (reg_rd && reg_addr > 8'h63 |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_fmax_cap:
        assert property (reg_rd && reg_addr == 8'h05 |=> reg_rdata <= 32'd25000)
        else $error("maximum frequency above ceiling");
    a_start_on_change:
        assert property ($rose(axis_in_motion_output) |-> $past(cmd_mode) != $past(cmd_mode, 2))
        else $error("motion without mode change");
    a_run_zero:
        assert property (cmd_mode == 8'h03 && $past(cmd_mode) != 8'h03 && cmd_frequency == 32'h0
            |=> !axis_in_motion_output) else $error("zero run did not stop");
    a_limit_stop:
        assert property (!travel_limit_a_b && !dir_out && axis_in_motion_output
            |-> ##[0:4] !axis_in_motion_output) else $error("backward limit ignored");
endmodule
bind spmc_top spmc_props u_props (.*);

// [spmc_pulse_gen.v]
`timescale 1ns/10ps
`include "spmc_defines.vh"
module spmc_pulse_gen (
    // clock and reset
    input  wire        clock,
    input  wire        rst_b,
    // control
    input  wire        enable,
    input  wire [31:0] freq,
    // one-cycle pulse strobe
    output wire        tick
);
    reg  [31:0] acc_r;   // phase accumulator
    wire [31:0] sum;     // next phase before wrap

    assign sum  = acc_r + freq;
    assign tick = enable && (sum >= `SPMC_CLK_HZ);

    // phase accumulator: one tick per clock-rate worth of frequency
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            acc_r <= 32'h0;
        end else if (!enable) begin
            // restart phase so the first pulse comes one period after start
            acc_r <= 32'h0;
        end else if (tick) begin
            acc_r <= sum - `SPMC_CLK_HZ;
        end else begin
            acc_r <= sum;
        end
    end
endmodule

// [spmc_sync.v]
`timescale 1ns/10ps
module spmc_sync #(
    parameter W = 1
) (
    // clock and reset
    input  wire         clock,
    input  wire         rst_b,
    // asynchronous input and synchronised output
    input  wire [W-1:0] din,
    output wire [W-1:0] dout
);
    reg [W-1:0] meta_r; // first stage, read only by the second
    reg [W-1:0] sync_r; // second stage

    // two flip-flop synchroniser
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
        end
    end

    assign dout = sync_r;
endmodule

// [spmc_top.v]
// What this block does
// - index selects parameter, value bytes supply it
// - start frequency, default 200, floor 125
// - three-stage ramp with three increments
// - maximum frequency, default 15000, up to 25000
// - positioning frequency, default 15000
// - reference run frequency, default 1000
// - steps between recalculations, minimum 10
// - motor, set and target frequency read-only
// - selector 61h saves parameters to flash
// - selector 62h reloads parameters from flash
// - selector 63h restores factory defaults
// - increment ordering recommended, partly corrected
// - act only on mode change, idle between
// - relative move adds signed count
// - absolute move to given position
// - motion output while moving, reached on arrival
// - moves use configured or default parameters
// - continuous run, floor 125, capped at maximum
// - new run frequency in the same direction taken immediately on reselect
// - run with zero frequency stops drive
// - fourteen-byte command block sampled cyclically
// - parameter committed on mode 05h or on an access-port write
// - limit trip stops, only opposite direction allowed
`timescale 1ns/10ps
`include "spmc_defines.vh"
module spmc_top (
    // clock and reset
    input  wire        clock,
    input  wire        rst_b,
    // command block from host logic
    input  wire [31:0] cmd_position,
    input  wire [31:0] cmd_frequency,
    input  wire [7:0]  cmd_mode,
    input  wire [7:0]  cmd_index,
    input  wire [31:0] cmd_value,
    // parameter access port
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output wire [31:0] reg_rdata,
    // travel limit pins, low when tripped
    input  wire        travel_limit_a_b,
    input  wire        travel_limit_b_b,
    // drive outputs
    output wire        pulse_out,
    output wire        dir_out,
    output wire        axis_in_motion_output,
    output wire        position_reached_output
);
    localparam ST_IDLE = 3'b001;
    localparam ST_POS  = 3'b010;
    localparam ST_RUN  = 3'b100;

    reg  [31:0] param_r [0:`SPMC_NPARAM-1]; // working parameter set
    reg  [31:0] flash_r [0:`SPMC_NPARAM-1]; // saved parameter set
    reg  [2:0]  state_r;                    // drive state
    reg  [7:0]  mode_prev_r;                // mode seen last cycle
    reg  [31:0] pos_r;                      // actual position, signed
    reg  [31:0] tgt_pos_r;                  // move destination
    reg  [31:0] cur_f_r;                    // present pulse frequency
    reg  [31:0] tgt_f_r;                    // ramp target frequency
    reg  [31:0] set_f_r;                    // commanded frequency
    reg  [31:0] pulse_cnt_r;                // steps since last recalc
    reg  [31:0] acc_steps_r;                // steps spent accelerating
    reg         dir_r;                      // 1 forward
    reg         pulse_r;                    // pulse strobe
    reg         motion_r;                   // axis in motion
    reg         reached_r;                  // position reached
    reg  [31:0] rdata_r;                    // read data
    reg  [31:0] rd_mux;                     // read data selection
    integer     i;

    function [31:0] def_val;
        input [3:0] s;
        begin
            case (s)
                `SPMC_S_FSTART: def_val = `SPMC_DEF_FSTART;
                `SPMC_S_FLIM1:  def_val = `SPMC_DEF_FLIM1;
                `SPMC_S_INC1:   def_val = `SPMC_DEF_INC1;
                `SPMC_S_FLIM2:  def_val = `SPMC_DEF_FLIM2;
                `SPMC_S_INC2:   def_val = `SPMC_DEF_INC2;
                `SPMC_S_FMAX:   def_val = `SPMC_DEF_FMAX;
                `SPMC_S_INC3:   def_val = `SPMC_DEF_INC3;
                `SPMC_S_FPOS:   def_val = `SPMC_DEF_FPOS;
                `SPMC_S_FREF:   def_val = `SPMC_DEF_FREF;
                `SPMC_S_STEPS:  def_val = `SPMC_DEF_STEPS;
                default:        def_val = 32'h0;
            endcase
        end
    endfunction

    // limit pins come from outside the clock domain
    wire [1:0] lim_ok;
    spmc_sync #(.W(2)) u_lim_sync (
        .clock (clock),
        .rst_b (rst_b),
        .din   ({travel_limit_a_b, travel_limit_b_b}),
        .dout  (lim_ok)
    );
    wire lim_a_trip = ~lim_ok[1]; // limit a guards backward travel
    wire lim_b_trip = ~lim_ok[0]; // limit b guards forward travel

    // start frequency never below its floor
    wire [31:0] p_fstart  = param_r[`SPMC_S_FSTART];
    wire [31:0] eff_start = (p_fstart < `SPMC_FSTART_MIN) ? `SPMC_FSTART_MIN : p_fstart;
    // first increment at or above start becomes half the start; zero increments would never ramp
    wire [31:0] p_inc1    = param_r[`SPMC_S_INC1];
    wire [31:0] eff_inc1  = (p_inc1 == 32'h0) ? 32'h1 :
                            (p_inc1 >= eff_start) ? (eff_start >> 1) : p_inc1;
    wire [31:0] eff_inc2  = (param_r[`SPMC_S_INC2] == 32'h0) ? 32'h1 : param_r[`SPMC_S_INC2];
    wire [31:0] eff_inc3  = (param_r[`SPMC_S_INC3] == 32'h0) ? 32'h1 :
                            param_r[`SPMC_S_INC3];
    // maximum is held at or above the start frequency
    wire [31:0] eff_fmax  = (param_r[`SPMC_S_FMAX] < eff_start) ? eff_start :
                            param_r[`SPMC_S_FMAX];
    wire [31:0] eff_steps = (param_r[`SPMC_S_STEPS] < `SPMC_STEPS_MIN) ? `SPMC_STEPS_MIN :
                            param_r[`SPMC_S_STEPS];
    // positioning frequency, clamped into the start..max band
    wire [31:0] p_fpos    = param_r[`SPMC_S_FPOS];
    wire [31:0] pos_freq  = (p_fpos > eff_fmax) ? eff_fmax :
                            (p_fpos < eff_start) ? eff_start : p_fpos;

    // stage increment chosen by the band the present frequency sits in
    wire [31:0] stage_inc = (cur_f_r < param_r[`SPMC_S_FLIM1]) ? eff_inc1 :
                            (cur_f_r < param_r[`SPMC_S_FLIM2]) ? eff_inc2 : eff_inc3;
    wire [31:0] up_f      = cur_f_r + stage_inc;
    wire [31:0] dn_f      = (cur_f_r > stage_inc) ? (cur_f_r - stage_inc) : 32'h0;

    // commands are recognised on a change of the mode byte only
    wire mode_new  = (cmd_mode != mode_prev_r);
    wire go_rel    = mode_new && (cmd_mode == `SPMC_MODE_REL);
    wire go_abs    = mode_new && (cmd_mode == `SPMC_MODE_ABS);
    wire go_run    = mode_new && (cmd_mode == `SPMC_MODE_RUN);
    wire go_param  = mode_new && (cmd_mode == `SPMC_MODE_PARAM);

    // sign gives direction, magnitude floored and capped
    wire        run_neg = cmd_frequency[31];
    wire [31:0] run_mag = run_neg ? (32'h0 - cmd_frequency) : cmd_frequency;
    wire [31:0] run_set = (run_mag == 32'h0) ? 32'h0 :
                          (run_mag < `SPMC_FSTART_MIN) ? `SPMC_FSTART_MIN :
                          (run_mag > eff_fmax) ? eff_fmax : run_mag;
    wire [31:0] run_f0  = (run_set < eff_start) ? run_set : eff_start;

    wire [31:0] new_tgt = go_rel ? (pos_r + cmd_position) : cmd_position;
    wire [31:0] new_rem = new_tgt - pos_r;
    wire        new_dir = ~new_rem[31];

    // travel still to go in the present move
    wire [31:0] rem     = tgt_pos_r - pos_r;
    wire [31:0] rem_abs = rem[31] ? (32'h0 - rem) : rem;

    // motion toward a tripped limit is refused or stopped
    wire blocked     = dir_r ? lim_b_trip : lim_a_trip;
    wire new_blocked = new_dir ? lim_b_trip : lim_a_trip;
    wire run_blocked = run_neg ? lim_a_trip : lim_b_trip;

    wire running = (state_r != ST_IDLE);
    wire tick;
    spmc_pulse_gen u_pulse (
        .clock  (clock),
        .rst_b  (rst_b),
        .enable (running),
        .freq   (cur_f_r),
        .tick   (tick)
    );
    wire recalc = tick && (pulse_cnt_r + 32'h1 >= eff_steps);
    // braking starts once remaining travel fits the ramp-up distance
    wire decel  = (rem_abs - 32'h1) <= acc_steps_r;

    // commit source, command block first, then the access port
    wire        cm_go  = go_param || reg_wr;
    wire [7:0]  cm_idx = go_param ? cmd_index : reg_addr;
    wire [31:0] cm_val = go_param ? cmd_value : reg_wdata;

    // parameter storage, flash copy and defaults
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            for (i = 0; i < `SPMC_NPARAM; i = i + 1) begin
                param_r[i] <= def_val(i[3:0]);
                flash_r[i] <= def_val(i[3:0]);
            end
        end else if (cm_go) begin
            if (cm_idx == `SPMC_IDX_STORE) begin
                for (i = 0; i < `SPMC_NPARAM; i = i + 1) begin
                    flash_r[i] <= param_r[i];
                end
            end else if (cm_idx == `SPMC_IDX_LOAD) begin
                // flash back into the working set
                for (i = 0; i < `SPMC_NPARAM; i = i + 1) begin
                    param_r[i] <= flash_r[i];
                end
            end else if (cm_idx == `SPMC_IDX_DEFAULT) begin
                for (i = 0; i < `SPMC_NPARAM; i = i + 1) begin
                    param_r[i] <= def_val(i[3:0]);
                end
            end else if (cm_idx == `SPMC_IDX_FMAX) begin
                // out-of-range maximum is ignored, old value stays
                if (cm_val <= `SPMC_FMAX_LIMIT) begin
                    param_r[`SPMC_S_FMAX] <= cm_val;
                end
            end else if (cm_idx <= `SPMC_IDX_STEPS) begin
                // plain writable selector; read-only ones fall outside
                param_r[cm_idx[3:0]] <= cm_val;
            end
        end
    end

    // readback of parameters and live frequencies
    always @* begin
        rd_mux = 32'h0;
        if (reg_addr <= `SPMC_IDX_STEPS) begin
            rd_mux = param_r[reg_addr[3:0]];
        end else if (reg_addr == `SPMC_IDX_FMOTOR) begin
            rd_mux = cur_f_r;
        end else if (reg_addr == `SPMC_IDX_FSET) begin
            rd_mux = set_f_r;
        end else if (reg_addr == `SPMC_IDX_FTGT) begin
            rd_mux = tgt_f_r;
        end
    end

    // read data register, held until the next read
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= 32'h0;
        end else if (reg_rd) begin
            rdata_r <= rd_mux;
        end
    end

    // mode byte sampled every cycle for change detection
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mode_prev_r <= `SPMC_MODE_IDLE;
        end else begin
            mode_prev_r <= cmd_mode;
        end
    end

    // drive sequencer: start, ramp, pulse, arrive, stop
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r     <= ST_IDLE;
            pos_r       <= 32'h0;
            tgt_pos_r   <= 32'h0;
            cur_f_r     <= 32'h0;
            tgt_f_r     <= 32'h0;
            set_f_r     <= 32'h0;
            pulse_cnt_r <= 32'h0;
            acc_steps_r <= 32'h0;
            dir_r       <= 1'b1;
            pulse_r     <= 1'b0;
            motion_r    <= 1'b0;
            reached_r   <= 1'b0;
        end else begin
            pulse_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if ((go_rel || go_abs) && (new_rem != 32'h0) && !new_blocked) begin
                        // ramp from start toward the positioning frequency
                        state_r     <= ST_POS;
                        tgt_pos_r   <= new_tgt;
                        dir_r       <= new_dir;
                        cur_f_r     <= eff_start;
                        tgt_f_r     <= pos_freq;
                        set_f_r     <= pos_freq;
                        pulse_cnt_r <= 32'h0;
                        acc_steps_r <= 32'h0;
                        motion_r    <= 1'b1;
                        reached_r   <= 1'b0;
                    end else if ((go_rel || go_abs) && (new_rem == 32'h0)) begin
                        // already there: nothing to travel
                        reached_r   <= 1'b1;
                    end else if (go_run && (run_set != 32'h0) && !run_blocked) begin
                        state_r     <= ST_RUN;
                        dir_r       <= ~run_neg;
                        cur_f_r     <= run_f0;
                        tgt_f_r     <= run_set;
                        set_f_r     <= run_set;
                        pulse_cnt_r <= 32'h0;
                        motion_r    <= 1'b1;
                        reached_r   <= 1'b0;
                    end
                end
                ST_POS: begin
                    if (blocked || (go_run && (run_set == 32'h0))) begin
                        // zero run or limit stops a move at once
                        state_r  <= ST_IDLE;
                        cur_f_r  <= 32'h0;
                        motion_r <= 1'b0;
                    end else if (tick) begin
                        // one pulse per increment, position follows direction
                        pulse_r     <= 1'b1;
                        pos_r       <= dir_r ? (pos_r + 32'h1) : (pos_r - 32'h1);
                        pulse_cnt_r <= recalc ? 32'h0 : (pulse_cnt_r + 32'h1);
                        if (!decel && (cur_f_r < tgt_f_r)) begin
                            acc_steps_r <= acc_steps_r + 32'h1;
                        end
                        if (rem_abs == 32'h1) begin
                            // arrival drops motion and flags reached
                            state_r   <= ST_IDLE;
                            cur_f_r   <= 32'h0;
                            motion_r  <= 1'b0;
                            reached_r <= 1'b1;
                        end else if (recalc && decel) begin
                            // brake with the stage increments, floor at start
                            cur_f_r <= (dn_f < eff_start) ? eff_start : dn_f;
                        end else if (recalc && (cur_f_r < tgt_f_r)) begin
                            cur_f_r <= (up_f > tgt_f_r) ? tgt_f_r : up_f;
                        end
                    end
                end
                ST_RUN: begin
                    if (blocked || (go_run && (run_set == 32'h0))) begin
                        // zero frequency or limit stops at once
                        state_r  <= ST_IDLE;
                        cur_f_r  <= 32'h0;
                        set_f_r  <= 32'h0;
                        motion_r <= 1'b0;
                    end else if (go_run && (dir_r == run_neg)) begin
                        // reversal is not done on the fly; stop first
                        state_r  <= ST_IDLE;
                        cur_f_r  <= 32'h0;
                        motion_r <= 1'b0;
                    end else if (go_run) begin
                        cur_f_r <= run_set;
                        tgt_f_r <= run_set;
                        set_f_r <= run_set;
                    end else if (tick) begin
                        pulse_r     <= 1'b1;
                        pos_r       <= dir_r ? (pos_r + 32'h1) : (pos_r - 32'h1);
                        pulse_cnt_r <= recalc ? 32'h0 : (pulse_cnt_r + 32'h1);
                        if (recalc && (cur_f_r < tgt_f_r)) begin
                            // stage ramp up to the run frequency
                            cur_f_r <= (up_f > tgt_f_r) ? tgt_f_r : up_f;
                        end
                    end
                end
                default: begin
                    state_r  <= ST_IDLE;
                    cur_f_r  <= 32'h0;
                    motion_r <= 1'b0;
                end
            endcase
        end
    end

    assign reg_rdata               = rdata_r;
    assign pulse_out               = pulse_r;
    assign dir_out                 = dir_r;
    assign axis_in_motion_output   = motion_r;
    assign position_reached_output = reached_r;
endmodule

// [spmc_top_tb.sv]
`timescale 1ns/10ps
module spmc_top_tb;
    logic        clock, rst_b, reg_wr, reg_rd, pulse_out, dir_out;
    logic        travel_limit_a_b, travel_limit_b_b;
    logic        axis_in_motion_output, position_reached_output;
    logic [7:0]  cmd_mode, cmd_index, reg_addr;
    logic [31:0] cmd_position, cmd_frequency, cmd_value, reg_wdata, reg_rdata;
    int          bad_count, check_count, cycles, nsteps;
    // reference parameter set, working and saved copies
    int          dflt[10] = '{200, 4000, 100, 10000, 60, 15000, 40, 15000, 1000, 10};
    int          pm[10], fl[10];
    logic [31:0] seed = 32'hc6f46048;
    spmc_host host (.*);
    spmc_top dut (.*);
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // hang guard, well above the two short moves
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            close_out();
        end
    end
    // count drive pulses as the design launched them
    always @(posedge clock) if (pulse_out === 1'b1) nsteps++;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // write strobe one cycle, model follows the accept rules
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
        if (a < 8'h0a && !(a == 8'h05 && d > 32'd25000)) pm[a] = d;
    endtask
    // read data is looked at in the one cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1 check(reg_rdata, e);
    endtask
    task automatic rd_all;
        for (int i = 0; i < 10; i++) rd(8'(i), pm[i]);
    endtask
    task automatic wait_reached;
        for (int n = 0; n < 20000 && position_reached_output !== 1'b1; n++) @(posedge clock);
    endtask
    task automatic close_out;
        $display("checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        travel_limit_a_b = 1'b1;
        travel_limit_b_b = 1'b1;
        rst_b = 1'b0;
        pm = dflt;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        rd_all();
        rd(8'h70, 32'h0);
        rd(8'h0a, 32'h0);
        $display("defaults done");
        // random values into the spare parameters
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            wr(seed[0] ? 8'h08 : 8'h09, {16'h0, seed[31:16]});
            rd(seed[0] ? 8'h08 : 8'h09, pm[seed[0] ? 8 : 9]);
        end
        wr(8'h05, 32'd25001);
        rd(8'h05, pm[5]);
        wr(8'h0a, 32'h55);
        rd(8'h0a, 32'h0);
        host.send(8'h05, 0, 0, 8'h07, 32'd20000);
        pm[7] = 20000;
        rd(8'h07, pm[7]);
        host.send(8'h05, 0, 0, 8'h61, 0);
        fl = pm;
        wr(8'h07, 32'd300);
        host.send(8'h05, 0, 0, 8'h62, 0);
        pm = fl;
        rd_all();
        host.send(8'h05, 0, 0, 8'h63, 0);
        pm = dflt;
        rd_all();
        $display("parameters done");
        wr(8'h00, 32'd50);
        host.send(8'h03, 0, 32'd1000, 0, 0);
        #1 check(axis_in_motion_output, 1'b1);
        rd(8'h0b, 32'd1000);
        rd(8'h0a, 32'd125);
        host.send(8'h03, 0, 32'd2000, 0, 0);
        rd(8'h0a, 32'd2000);
        host.send(8'h03, 0, 32'd30000, 0, 0);
        rd(8'h0b, 32'd15000);
        host.send(8'h03, 0, 32'd50, 0, 0);
        rd(8'h0b, 32'd125);
        host.send(8'h03, 0, 32'h0, 0, 0);
        #1 check(axis_in_motion_output, 1'b0);
        host.send(8'h03, 0, 32'h800003e8, 0, 0);
        #1 check(dir_out, 1'b0);
        @(posedge clock) travel_limit_a_b <= 1'b0;
        repeat (5) @(posedge clock);
        #1 check(axis_in_motion_output, 1'b0);
        host.send(8'h01, 32'hffffffff, 0, 0, 0);
        repeat (3) @(posedge clock);
        #1 check(axis_in_motion_output, 1'b0);
        @(posedge clock) travel_limit_a_b <= 1'b1;
        repeat (3) @(posedge clock);
        $display("run and limit done");
        wr(8'h05, 32'd25000);
        wr(8'h00, 32'd25000); // start frequency raised to 25000
        wr(8'h07, 32'd25000);
        nsteps = 0;
        host.send(8'h08, 32'd2, 0, 0, 0);
        #1 check(axis_in_motion_output, 1'b1);
        check(dir_out, 1'b1);
        wait_reached();
        #1 check({axis_in_motion_output, position_reached_output}, 2'b01);
        check(nsteps, 2);
        host.send(8'h01, 32'hfffffffe, 0, 0, 0);
        #1 check(dir_out, 1'b0);
        wait_reached();
        #1 check(position_reached_output, 1'b1);
        check(nsteps, 4);
        $display("moves done");
        close_out();
    end
endmodule
